// >>> src/pdp_defines.svh
`ifndef PDP_DEFINES_SVH
`define PDP_DEFINES_SVH
// ==========================================================
// register map
`define PDP_ADDR_CFG 4'h0
`define PDP_ADDR_DLY 4'h1
`define PDP_ADDR_CNT 4'h2
`define PDP_ADDR_STAT 4'h3
`define PDP_ADDR_RXD 4'h4
`define PDP_ADDR_TXD 4'h5
`define PDP_ADDR_LPF 4'h6
// ==========================================================
// configuration fields
`define PDP_CFG_EN 0
`define PDP_CFG_DIR 1
`define PDP_CFG_VID 2
`define PDP_CFG_SUB_LO 3
`define PDP_CFG_SUB_HI 4
`define PDP_CFG_W_LO 5
`define PDP_CFG_W_HI 7
`define PDP_CFG_FS_LO 8
`define PDP_CFG_FS_HI 9
// ==========================================================
// video timing reference codes
`define PDP_PRE0 8'hFF
`define PDP_PRE12 8'h00
`define PDP_XY_F 6
`define PDP_XY_V 5
`define PDP_XY_H 4
// link rate limit: port clock period at least two system clocks
`define PDP_MIN_HALF 2
`endif

// >>> src/pdp_pkg.sv
package pdp_pkg;
  typedef enum logic [1:0] {
    PDP_GP_IN = 2'b00,
    PDP_GP_CAP = 2'b01,
    PDP_GP_OUT = 2'b10
  } pdp_gp_e;
  typedef enum logic [1:0] {
    PDP_V_ACT = 2'b00,
    PDP_V_VBI = 2'b01,
    PDP_V_ALL = 2'b10
  } pdp_vid_e;
  typedef enum logic [2:0] {
    PDP_S_IDLE = 3'b000,
    PDP_S_DLY = 3'b001,
    PDP_S_RUN = 3'b010,
    PDP_S_SYNC = 3'b011,
    PDP_S_VID = 3'b100
  } pdp_state_e;
endpackage

// >>> src/pdp_port.sv
// Local design decisions: strobed register access and the register offsets.
`include "pdp_defines.svh"
// parallel_data_port: general purpose and video modes, one direction at a time
module pdp_port
  import pdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic port_input_clock,
  input wire logic [2:0] fs_in,
  output logic [2:0] fs_out,
  output logic [2:0] fs_oe,
  input wire logic [15:0] pd_in,
  output logic [15:0] pd_out,
  output logic pd_oe,
  output logic rx_valid,
  output logic [15:0] rx_word,
  output logic tx_take
);
  // ==========================================================
  // registers
  logic [15:0] port_configuration_r;
  logic [15:0] sync_to_data_delay_r;
  logic [15:0] transfer_count_setting_r;
  logic [15:0] line_period_r;
  logic [15:0] tx_word_r;
  logic [15:0] rdata_r;
  logic [15:0] rx_word_r;
  logic rx_valid_r;
  logic tx_take_r;
  logic [2:0] fs_out_r;
  logic [2:0] fs_oe_r;
  logic [15:0] pd_out_r;
  logic pd_oe_r;
  // ==========================================================
  // synchronisers; first stage feeds only the second
  // one port clock, three sync lines and sixteen data lines cross here
  logic [2:0] clk_s_r;
  logic [2:0] fs_m_r, fs_s_r;
  logic [15:0] pd_m_r, pd_s_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s_r <= 3'h0;
      fs_m_r <= 3'h0;
      fs_s_r <= 3'h0;
      pd_m_r <= 16'h0;
      pd_s_r <= 16'h0;
    end else begin
      clk_s_r <= {clk_s_r[1:0], port_input_clock};
      fs_m_r <= fs_in;
      fs_s_r <= fs_m_r;
      pd_m_r <= pd_in;
      pd_s_r <= pd_m_r;
    end
  end
  // port clock edges seen in the core domain; the clock may not exceed half core rate
  wire pclk_rise = clk_s_r[1] & ~clk_s_r[2];
  wire pclk_fall = ~clk_s_r[1] & clk_s_r[2];
  // ==========================================================
  // configuration decode
  wire en = port_configuration_r[`PDP_CFG_EN];
  wire dir_out = port_configuration_r[`PDP_CFG_DIR];
  wire vid = port_configuration_r[`PDP_CFG_VID];
  wire [1:0] sub = port_configuration_r[`PDP_CFG_SUB_HI:`PDP_CFG_SUB_LO];
  wire [2:0] wsel = port_configuration_r[`PDP_CFG_W_HI:`PDP_CFG_W_LO];
  wire [1:0] nfs = port_configuration_r[`PDP_CFG_FS_HI:`PDP_CFG_FS_LO];
  // single direction: output only for gp output submode, or video with dir set
  wire drive_data = en & (vid ? dir_out : (sub == PDP_GP_OUT));
  wire gp_in = en & ~vid & (sub == PDP_GP_IN);
  wire gp_cap = en & ~vid & (sub == PDP_GP_CAP);
  wire gp_out = en & ~vid & (sub == PDP_GP_OUT);
  wire vid_in = en & vid & ~dir_out;
  // ==========================================================
  // width mask: 0 means 8 bits, n means 9+n bits; video uses bit 0 only, 10 bits if set, else 8
  logic [15:0] wmask;
  always_comb begin
    wmask = 16'h00FF;
    if (vid) begin
      wmask = wsel[0] ? 16'h03FF : 16'h00FF;
    end else if (wsel != 3'h0) begin
      wmask = 16'hFFFF >> (3'h7 - wsel);
    end
  end
  wire [15:0] din = pd_s_r & wmask;
  wire [7:0] dv = vid && wsel[0] ? din[9:2] : din[7:0];
  // ==========================================================
  // preamble detector: FF 00 00 XY
  logic [1:0] pre_r;
  logic f_r, v_r, h_r;
  wire xy_now = (pre_r == 2'h3);
  wire in_pre = (pre_r != 2'h0) | (dv == `PDP_PRE0);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 2'h0;
      f_r <= 1'b0;
      v_r <= 1'b1;
      h_r <= 1'b1;
    end else if (pclk_rise && vid_in) begin
      if (dv == `PDP_PRE0 && pre_r != 2'h3) begin
        pre_r <= 2'h1;
      end else if ((pre_r == 2'h1 || pre_r == 2'h2) && dv == `PDP_PRE12) begin
        pre_r <= pre_r + 2'h1;
      end else begin
        pre_r <= 2'h0;
      end
      if (xy_now) begin
        f_r <= dv[`PDP_XY_F];
        v_r <= dv[`PDP_XY_V];
        h_r <= dv[`PDP_XY_H];
      end
    end
  end
  // ==========================================================
  // sequencer
  pdp_state_e st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] lcnt_r, lcnt_nxt;
  logic fs1_d_r;
  wire fs1_rise = fs_s_r[0] & ~fs1_d_r;
  wire out_mode = gp_cap | gp_out;
  wire sav = xy_now & ~dv[`PDP_XY_H];
  wire eav = xy_now & dv[`PDP_XY_H];
  wire f1_start = xy_now & ~dv[`PDP_XY_F] & f_r; // field 2 to field 1
  wire line_end = (cnt_r == line_period_r);
  logic take;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    lcnt_nxt = lcnt_r;
    take = 1'b0;
    case (st_r)
      PDP_S_IDLE: begin
        cnt_nxt = 16'h0;
        lcnt_nxt = 16'h0;
        if (gp_in && fs1_rise) begin
          st_nxt = PDP_S_DLY;
        end else if (out_mode) begin
          st_nxt = PDP_S_RUN;
        end else if (vid_in) begin
          st_nxt = PDP_S_SYNC;
        end
      end
      PDP_S_DLY: begin
        if (cnt_r >= sync_to_data_delay_r) begin
          st_nxt = PDP_S_RUN;
          cnt_nxt = 16'h0;
        end else begin
          cnt_nxt = cnt_r + 16'h1;
        end
      end
      PDP_S_RUN: begin
        if (gp_in) begin
          take = 1'b1;
          cnt_nxt = cnt_r + 16'h1;
          if (cnt_r + 16'h1 >= transfer_count_setting_r) begin
            st_nxt = PDP_S_IDLE;
          end
        end else begin
          // frame timing generator for driven syncs
          take = 1'b1;
          cnt_nxt = line_end ? 16'h0 : cnt_r + 16'h1;
          if (line_end) begin
            lcnt_nxt = (lcnt_r >= transfer_count_setting_r) ? 16'h0 : lcnt_r + 16'h1;
          end
        end
      end
      PDP_S_SYNC: begin
        if (f1_start) begin
          st_nxt = PDP_S_VID;
        end
      end
      PDP_S_VID: begin
        // three video submodes share one decoder
        case (sub)
          PDP_V_ACT: take = ~v_r & ~h_r & ~in_pre & ~xy_now;
          PDP_V_VBI: take = v_r & ~in_pre & ~xy_now;
          default: take = 1'b1;
        endcase
        if (sub == PDP_V_ACT && eav && !v_r) begin
          lcnt_nxt = lcnt_r + 16'h1;
          if (lcnt_r + 16'h1 >= transfer_count_setting_r) begin
            st_nxt = PDP_S_SYNC;
            lcnt_nxt = 16'h0;
          end
        end
        if (sav) begin
          cnt_nxt = 16'h0;
        end
      end
      default: st_nxt = PDP_S_IDLE;
    endcase
    if (!en) begin
      st_nxt = PDP_S_IDLE;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= PDP_S_IDLE;
      cnt_r <= 16'h0;
      lcnt_r <= 16'h0;
      fs1_d_r <= 1'b0;
    end else if (pclk_rise || !en) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lcnt_r <= lcnt_nxt;
      fs1_d_r <= fs_s_r[0];
    end
  end
  // ==========================================================
  // data capture towards memory side
  wire cap_now = pclk_rise & take & ~drive_data & en;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid_r <= 1'b0;
      rx_word_r <= 16'h0;
    end else begin
      rx_valid_r <= cap_now;
      if (cap_now) begin
        rx_word_r <= din;
      end
    end
  end
  // ==========================================================
  // driven side: updated on falling port clock so the partner samples mid-cycle
  wire hs_n = ~(cnt_r == 16'h0);
  wire vs_n = ~(lcnt_r == 16'h0);
  wire [2:0] fs_gen = {~(hs_n | vs_n), vs_n, hs_n};
  // frame capture always needs hsync and vsync, whatever the sync count says
  wire [2:0] fs_cnt = (nfs == 2'h0) ? 3'b001 : (nfs == 2'h1) ? 3'b011 : 3'b111;
  wire [2:0] fs_use = gp_cap ? 3'b011 : fs_cnt;
  wire [2:0] oe_nxt = out_mode ? fs_use : 3'h0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_out_r <= 3'h0;
      fs_oe_r <= 3'h0;
      pd_out_r <= 16'h0;
      pd_oe_r <= 1'b0;
      tx_take_r <= 1'b0;
    end else begin
      fs_oe_r <= oe_nxt;
      pd_oe_r <= drive_data;
      tx_take_r <= 1'b0;
      if (pclk_fall) begin
        fs_out_r <= fs_gen & oe_nxt;
        if (drive_data) begin
          pd_out_r <= tx_word_r & wmask;
          tx_take_r <= 1'b1;
        end
      end
    end
  end
  // ==========================================================
  // register port
  wire [15:0] stat = {10'h0, f_r, v_r, h_r, st_r};
  logic [15:0] rd_mux;
  always_comb begin
    case (addr)
      `PDP_ADDR_CFG: rd_mux = port_configuration_r;
      `PDP_ADDR_DLY: rd_mux = sync_to_data_delay_r;
      `PDP_ADDR_CNT: rd_mux = transfer_count_setting_r;
      `PDP_ADDR_STAT: rd_mux = stat;
      `PDP_ADDR_RXD: rd_mux = rx_word_r;
      `PDP_ADDR_TXD: rd_mux = tx_word_r;
      `PDP_ADDR_LPF: rd_mux = line_period_r;
      default: rd_mux = 16'h0;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_configuration_r <= 16'h0;
      sync_to_data_delay_r <= 16'h0;
      transfer_count_setting_r <= 16'h0;
      line_period_r <= 16'h0;
      tx_word_r <= 16'h0;
      rdata_r <= 16'h0;
    end else begin
      rdata_r <= rd ? rd_mux : 16'h0;
      if (wr) begin
        case (addr)
          `PDP_ADDR_CFG: port_configuration_r <= wdata;
          `PDP_ADDR_DLY: sync_to_data_delay_r <= wdata;
          `PDP_ADDR_CNT: transfer_count_setting_r <= wdata;
          `PDP_ADDR_TXD: tx_word_r <= wdata;
          `PDP_ADDR_LPF: line_period_r <= wdata;
          default: ;
        endcase
      end
    end
  end
  assign rdata = rdata_r;
  assign rx_valid = rx_valid_r;
  assign rx_word = rx_word_r;
  assign tx_take = tx_take_r;
  assign fs_out = fs_out_r;
  assign fs_oe = fs_oe_r;
  assign pd_out = pd_out_r;
  assign pd_oe = pd_oe_r;
  // ==========================================================
  // checks
  idle_when_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !en |=> st_r == PDP_S_IDLE) else $error("not idle while disabled");
  one_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pd_oe |-> !rx_valid) else $error("both directions active");
  cap_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_valid |-> $past(pclk_rise)) else $error("capture off port edge");
  width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_valid |-> (rx_word & ~wmask) == 16'h0) else $error("unused lines captured");
  cap_syncs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    gp_cap |=> fs_oe == 3'b011) else $error("capture syncs wrong");
  fs_in_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    gp_in |=> fs_oe == 3'h0) else $error("sync driven in input mode");
  wait_sync_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == PDP_S_SYNC && vid_in |-> !cap_now) else $error("data before field one");
  pre_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cap_now && vid && sub == PDP_V_ACT |-> !xy_now && !in_pre) else $error("code stored");
  cnt_end_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == PDP_S_RUN && gp_in && pclk_rise && cnt_r + 16'h1 >= transfer_count_setting_r
    |=> st_r == PDP_S_IDLE) else $error("count overrun");
  cv_gp_in_c: cover property (@(posedge core_clk) gp_in && cap_now);
  cv_vid_c: cover property (@(posedge core_clk) st_r == PDP_S_VID && cap_now);
  cv_out_c: cover property (@(posedge core_clk) tx_take);
endmodule

// >>> verif/pdp_far_end.sv
// converter model on the far side of the parallel data port
module pdp_far_end
  import pdp_pkg::*;
(
  output logic port_input_clock,
  output logic [2:0] fs_in,
  output logic [15:0] pd_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // pins at rest
  // clock parked low between frames; data never holds its last value
  initial begin
    port_input_clock = 1'b0;
    fs_in = 3'b000;
    pd_in = 16'h0000;
  end
  task automatic rest(input logic [15:0] d);
    port_input_clock = 1'b0;
    fs_in = 3'b000;
    pd_in = ~d;
  endtask
  // one port clock of 160 ns; pins move in the low phase, settled at the rise
  task automatic tick(input logic [15:0] d, input logic [2:0] fs);
    port_input_clock = 1'b0;
    pd_in = d;
    fs_in = fs;
    #80;
    port_input_clock = 1'b1;
    #80;
  endtask
  // one quiet clock first so the first sync always shows a rising edge
  task automatic gp_frame(input logic [15:0] d, input int n);
    tick(~d, 3'b000);
    for (int i = 0; i < n; i++) begin
      tick(d, 3'b001);
    end
    rest(d);
  endtask
endmodule

// >>> verif/pdp_port_tb_top.sv
`include "pdp_defines.svh"
// self-checking bench: drivers note expectations for one monitor, the main sequence checks the rest
module pdp_port_tb_top
  import pdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, wr, rd, rd_seen, pd_oe, rx_valid, tx_take;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, pd_in, pd_out, rx_word, v, mask;
  logic [2:0] fs_in, fs_out, fs_oe;
  wire port_input_clock;
  logic [15:0] rq[$];
  logic [15:0] wq[$];
  int seed, checks, fail_count, w, i, a, m, base, dl, tx_n;
  time t_fs, t_first;
  logic [7:0] vb [0:25] = '{8'hFF, 8'h00, 8'h00, 8'hF0, 8'h10, 8'h10, 8'hFF, 8'h00,
    8'h00, 8'h90, 8'h10, 8'h10, 8'hFF, 8'h00, 8'h00, 8'h80, 8'hA1, 8'hA2, 8'hA3,
    8'hA4, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h10, 8'h10};
  int vk [0:25] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3,
    2, 2, 2, 2, 2, 2};
  pdp_port uut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .port_input_clock(port_input_clock),
    .fs_in(fs_in), .fs_out(fs_out), .fs_oe(fs_oe), .pd_in(pd_in), .pd_out(pd_out),
    .pd_oe(pd_oe), .rx_valid(rx_valid), .rx_word(rx_word), .tx_take(tx_take));
  pdp_far_end far (.port_input_clock(port_input_clock), .fs_in(fs_in), .pd_in(pd_in));
  // ====================
  // common tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] ad, input logic [15:0] e);
    @(posedge core_clk);
    addr <= ad;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge core_clk);
    rd <= 1'b0;
  endtask
  // ====================
  // clock, watchdog and monitor
  always #10 core_clk = ~core_clk;
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
  always @(posedge fs_in[0]) t_fs = $time;
  // read data stands only in the cycle after the strobe, so look exactly there
  always @(posedge core_clk) begin
    if (rd_seen === 1'b1) begin
      check(rdata, rq.pop_front());
    end
    rd_seen <= rd;
    if (tx_take === 1'b1) begin
      tx_n++;
    end
    if (rx_valid === 1'b1) begin
      if (t_first == 0) begin
        t_first = $time;
      end
      if (wq.size() == 0) begin
        check(16'h0000, 16'h0001);
      end else begin
        check(rx_word, wq.pop_front());
      end
    end
  end
  // ====================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    rd_seen = 1'b0;
    seed = 90549;
    tx_n = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    // register round trip, unmapped places read zero
    v = $random(seed);
    wreg(`PDP_ADDR_LPF, v);
    rreg(`PDP_ADDR_LPF, v);
    for (a = 7; a < 16; a++) begin
      wreg(a[3:0], 16'hFFFF);
      rreg(a[3:0], 16'h0000);
    end
    // a disabled port must let a whole frame pass unseen
    wreg(`PDP_ADDR_CNT, 16'h0004);
    far.gp_frame(16'h1234, 8);
    // input submode, every width, delay and count growing together
    for (w = 0; w < 8; w++) begin
      v = $random(seed);
      mask = (w == 0) ? 16'h00FF : 16'hFFFF >> (7 - w);
      wreg(`PDP_ADDR_DLY, w[15:0]);
      wreg(`PDP_ADDR_CNT, w[15:0] + 16'h0001);
      wreg(`PDP_ADDR_CFG, {6'h00, 2'b01, w[2:0], 5'b00001});
      repeat (4) @(posedge core_clk);
      check({12'h000, pd_oe, fs_oe}, 16'h0000);
      for (i = 0; i <= w; i++) begin
        wq.push_back(v & mask);
      end
      t_first = 0;
      far.gp_frame(v, w + w + 6);
      repeat (40) @(posedge core_clk);
      check(16'(wq.size()), 16'h0000);
      if (w == 0) begin
        base = int'(t_first - t_fs);
      end
      dl = int'(t_first - t_fs) - base - 160 * w;
      check({15'h0000, dl >= -20 && dl <= 20}, 16'h0001);
    end
    // capture drives two syncs only; output drives data and three syncs
    wreg(`PDP_ADDR_CFG, 16'h0209);
    repeat (4) @(posedge core_clk);
    check({12'h000, pd_oe, fs_oe}, 16'h0003);
    wreg(`PDP_ADDR_CFG, 16'h0311);
    repeat (4) @(posedge core_clk);
    check({12'h000, pd_oe, fs_oe}, 16'h000F);
    // output: written word leaves on each falling port edge, syncs at line start
    v = $random(seed);
    wreg(`PDP_ADDR_LPF, 16'h0010);
    wreg(`PDP_ADDR_TXD, v);
    tx_n = 0;
    for (i = 0; i < 3; i++) begin
      far.tick(16'h0000, 3'b000);
    end
    far.rest(16'h0000);
    repeat (6) @(posedge core_clk);
    check(pd_out, v & 16'h00FF);
    check({14'h0000, fs_out[1:0]}, 16'h0001);
    check(16'(tx_n), 16'h0003);
    // video: active only, blanking only, entire field, same embedded-code stream
    for (m = 0; m < 3; m++) begin
      wreg(`PDP_ADDR_CFG, 16'h0000);
      wreg(`PDP_ADDR_CNT, 16'h00FF);
      wreg(`PDP_ADDR_CFG, {11'h000, m[1:0], 3'b101});
      for (i = 0; i < 26; i++) begin
        if (m != 1 && (vk[i] == 3 || (m == 2 && vk[i] == 2))) begin
          wq.push_back({8'h00, vb[i]});
        end
      end
      for (i = 0; i < 26; i++) begin
        far.tick({8'h5A ^ i[7:0], vb[i]}, 3'b000);
      end
      far.rest(16'h0000);
      repeat (40) @(posedge core_clk);
      check(16'(wq.size()), 16'h0000);
    end
    finish_test();
  end
endmodule
